// file: hdl/dcf_pkg.sv
/*
  Shared constants and types for the DMA channel flag and setup block:
  register offsets, flag bit positions, reset values, carrier structs.
  Assumes a single 32-bit AHB-Lite register port and one clock domain.
*/
`default_nettype none

package dcf_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_CLEAR = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_SRC_START = 8'h0c;
  localparam logic [7:0] OFS_DST_START = 8'h10;
  localparam logic [7:0] OFS_SRC_LEN = 8'h14;
  localparam logic [7:0] OFS_DST_LEN = 8'h18;
  localparam logic [7:0] OFS_CELL_LEN = 8'h1c;
  localparam logic [7:0] OFS_CONTROL = 8'h20;
  localparam logic [7:0] OFS_SRC_PTR = 8'h24;
  localparam logic [7:0] OFS_DST_PTR = 8'h28;

  // flag bit positions
  localparam int FLAG_W = 5;
  localparam int BIT_DHALF = 4;
  localparam int BIT_BLOCK = 3;
  localparam int BIT_CELL = 2;
  localparam int BIT_ABORT = 1;
  localparam int BIT_ADDR_ERR = 0;

  // control register fields
  localparam int CTL_START = 0;
  localparam int CTL_ABORT_EN = 1;
  localparam int CTL_SEL_LSB = 8;
  localparam int CTL_SEL_MSB = 15;

  // reset values and the largest decoded length
  localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [15:0] LEN_RST = 16'h0000;
  localparam logic [7:0] ABORT_SEL_RST = 8'hff;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [16:0] LEN_MAX = 17'h1_0000;

  typedef enum logic {ST_IDLE, ST_MOVE} dcf_state_e_t;

  // addresses of the byte now requested
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
  } dcf_xfer_t;

  // system interrupt request seen by the channel
  typedef struct packed {
    logic valid;
    logic [7:0] num;
  } dcf_sysirq_t;

  typedef struct packed {
    logic [15:0] count;
  } dcf_cnt_state_t;

  typedef struct packed {
    dcf_state_e_t st;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] enable;
    logic [31:0] src_start;
    logic [31:0] dst_start;
    logic [15:0] src_len;
    logic [15:0] dst_len;
    logic [15:0] cell_len;
    logic abort_en;
    logic [7:0] abort_sel;
    dcf_xfer_t xfer;
    logic [16:0] total;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_addr;
  } dcf_state_t;

  // zero encodes the largest length
  function automatic logic [16:0] dcf_len_bytes(input logic [15:0] len);
    return (len == 16'h0000) ? LEN_MAX : {1'b0, len};
  endfunction

endpackage

`default_nettype wire

// file: hdl/dcf_wrap_count.sv
/*
  Byte counter that wraps at a programmed length.
  Assumes the length input is already decoded to a byte count of 1 to 65,536.
*/
`default_nettype none

module dcf_wrap_count
  import dcf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic step,
  input wire logic [16:0] len,
  output logic [15:0] count,
  output logic [15:0] next,
  output logic at_wrap,
  output logic at_half
);

  dcf_cnt_state_t s_q;
  dcf_cnt_state_t s_d;
  logic [16:0] inc;

  always_comb begin
    s_d = s_q;
    inc = {1'b0, s_q.count} + 17'h0_0001;
    at_wrap = (inc == len);
    at_half = (inc == {1'b0, len[16:1]});
    next = at_wrap ? 16'h0000 : inc[15:0];
    if (clear) begin
      s_d.count = 16'h0000;
    end else if (step) begin
      s_d.count = next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{count: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.count;

endmodule

`default_nettype wire

// file: hdl/dcf_channel.sv
/*
  One DMA channel: AHB-Lite register slave, source/destination setup,
  byte progress counters, five sticky event flags and one interrupt line.
  Assumes an external mover that takes one byte per xfer_ack, and a
  system interrupt bus giving one request number per cycle.
*/
// Chosen here: the register offsets and register access over AHB-Lite.
`default_nettype none

module dcf_channel
  import dcf_pkg::*;
#(
  parameter logic [31:0] VALID_LO = 32'h0000_0000,
  parameter logic [31:0] VALID_HI = 32'hffff_ffff
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  output logic busy,
  output logic xfer_req,
  output dcf_xfer_t xfer,
  input wire logic xfer_ack,
  input wire dcf_sysirq_t sys_irq,
  input wire logic pattern_match
);

  dcf_state_t s_q;
  dcf_state_t s_d;
  logic [FLAG_W-1:0] set_mask;
  logic [FLAG_W-1:0] clr_mask;
  logic start_req;
  logic ptr_clr;
  logic step;
  logic abort_hit;
  logic addr_bad;
  logic [31:0] rd_val;
  logic [16:0] src_bytes;
  logic [16:0] dst_bytes;
  logic [16:0] cell_bytes;
  logic [16:0] block_bytes;
  logic [16:0] total_nxt;
  logic [15:0] src_ptr;
  logic [15:0] dst_ptr;
  logic [15:0] src_next;
  logic [15:0] dst_next;
  logic cell_wrap;
  logic dst_half;
  logic addr_phase;

  function automatic logic addr_ok(input logic [31:0] a);
    return (a >= VALID_LO) && (a <= VALID_HI);
  endfunction

  dcf_wrap_count u_src (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(ptr_clr),
    .step(step),
    .len(src_bytes),
    .count(src_ptr),
    .next(src_next),
    .at_wrap(),
    .at_half()
  );

  dcf_wrap_count u_dst (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(ptr_clr),
    .step(step),
    .len(dst_bytes),
    .count(dst_ptr),
    .next(dst_next),
    .at_wrap(),
    .at_half(dst_half)
  );

  dcf_wrap_count u_cell (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(ptr_clr),
    .step(step),
    .len(cell_bytes),
    .count(),
    .next(),
    .at_wrap(cell_wrap),
    .at_half()
  );

  assign src_bytes = dcf_len_bytes(s_q.src_len);
  assign dst_bytes = dcf_len_bytes(s_q.dst_len);
  assign cell_bytes = dcf_len_bytes(s_q.cell_len);
  assign block_bytes = (src_bytes > dst_bytes) ? src_bytes : dst_bytes;
  assign total_nxt = s_q.total + 17'h0_0001;
  assign addr_phase = hsel && htrans[1] && hready;
  assign abort_hit = s_q.abort_en && sys_irq.valid && (sys_irq.num == s_q.abort_sel);

  always_comb begin
    s_d = s_q;
    set_mask = FLAGS_RST;
    clr_mask = FLAGS_RST;
    start_req = 1'b0;
    ptr_clr = 1'b0;
    step = 1'b0;
    addr_bad = 1'b0;
    rd_val = RDATA_RST;
    // data phase of a write
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        OFS_CLEAR: clr_mask = hwdata[FLAG_W-1:0];
        OFS_ENABLE: s_d.enable = hwdata[FLAG_W-1:0];
        OFS_SRC_START: s_d.src_start = hwdata;
        OFS_DST_START: s_d.dst_start = hwdata;
        OFS_SRC_LEN: s_d.src_len = hwdata[15:0];
        OFS_DST_LEN: s_d.dst_len = hwdata[15:0];
        OFS_CELL_LEN: s_d.cell_len = hwdata[15:0];
        OFS_CONTROL: begin
          s_d.abort_en = hwdata[CTL_ABORT_EN];
          s_d.abort_sel = hwdata[CTL_SEL_MSB:CTL_SEL_LSB];
          start_req = hwdata[CTL_START];
        end
        default: ;
      endcase
    end
    // transfer engine
    case (s_q.st)
      ST_IDLE: begin
        if (start_req) begin
          ptr_clr = 1'b1;
          s_d.total = 17'h0_0000;
          addr_bad = !addr_ok(s_d.src_start) || !addr_ok(s_d.dst_start);
          if (addr_bad) begin
            set_mask[BIT_ADDR_ERR] = 1'b1;
          end else begin
            s_d.st = ST_MOVE;
            s_d.xfer.src = s_d.src_start;
            s_d.xfer.dst = s_d.dst_start;
          end
        end
      end
      ST_MOVE: begin
        if (abort_hit) begin
          set_mask[BIT_ABORT] = 1'b1;
          s_d.st = ST_IDLE;
        end else if (pattern_match) begin
          set_mask[BIT_BLOCK] = 1'b1;
          s_d.st = ST_IDLE;
        end else if (xfer_ack) begin
          step = 1'b1;
          set_mask[BIT_CELL] = cell_wrap;
          set_mask[BIT_DHALF] = dst_half;
          s_d.xfer.src = s_q.src_start + {16'h0000, src_next};
          s_d.xfer.dst = s_q.dst_start + {16'h0000, dst_next};
          if (total_nxt == block_bytes) begin
            set_mask[BIT_BLOCK] = 1'b1;
            s_d.st = ST_IDLE;
          end else begin
            s_d.total = total_nxt;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // set wins over a clear in the same cycle
    s_d.flags = (s_q.flags & ~clr_mask) | set_mask;
    // read value reflects any write landing this cycle
    case (haddr[7:0])
      OFS_FLAGS: rd_val = {27'h000_0000, s_d.flags};
      OFS_ENABLE: rd_val = {27'h000_0000, s_d.enable};
      OFS_SRC_START: rd_val = s_d.src_start;
      OFS_DST_START: rd_val = s_d.dst_start;
      OFS_SRC_LEN: rd_val = {16'h0000, s_d.src_len};
      OFS_DST_LEN: rd_val = {16'h0000, s_d.dst_len};
      OFS_CELL_LEN: rd_val = {16'h0000, s_d.cell_len};
      OFS_CONTROL: rd_val = {16'h0000, s_d.abort_sel, 6'h00, s_d.abort_en, 1'b0};
      OFS_SRC_PTR: rd_val = {16'h0000, src_ptr};
      OFS_DST_PTR: rd_val = {16'h0000, dst_ptr};
      default: rd_val = RDATA_RST;
    endcase
    s_d.wr_pend = addr_phase && hwrite;
    if (addr_phase) begin
      s_d.wr_addr = haddr[7:0];
      if (!hwrite) begin
        s_d.rdata = rd_val;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{
        st: ST_IDLE,
        flags: FLAGS_RST,
        enable: FLAGS_RST,
        src_start: ADDR_RST,
        dst_start: ADDR_RST,
        src_len: LEN_RST,
        dst_len: LEN_RST,
        cell_len: LEN_RST,
        abort_en: 1'b0,
        abort_sel: ABORT_SEL_RST,
        xfer: '{src: ADDR_RST, dst: ADDR_RST},
        total: 17'h0_0000,
        rdata: RDATA_RST,
        wr_pend: 1'b0,
        wr_addr: 8'h00
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign irq = |(s_q.flags & s_q.enable);
  assign busy = (s_q.st == ST_MOVE);
  assign xfer_req = busy;
  assign xfer = s_q.xfer;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr_src_start;
    addr_phase && hwrite && (haddr[7:0] == OFS_SRC_START) ##1 1'b1;
  endsequence

  sequence s_rd_src_len;
    addr_phase && !hwrite && (haddr[7:0] == OFS_SRC_LEN);
  endsequence

  property p_src_start_rw;
    s_wr_src_start |=> (s_q.src_start == $past(hwdata));
  endproperty
  a_src_start_rw: assert property (p_src_start_rw) else $error("source start not stored");

  property p_src_len_upper;
    s_rd_src_len |=> (hrdata[31:16] == 16'h0000) && (hrdata[15:0] == $past(s_d.src_len));
  endproperty
  a_src_len_upper: assert property (p_src_len_upper) else $error("source length read wrong");

  property p_sticky_cell;
    s_q.flags[BIT_CELL] && !(s_q.wr_pend && (s_q.wr_addr == OFS_CLEAR) && hwdata[BIT_CELL])
      |=> s_q.flags[BIT_CELL];
  endproperty
  a_sticky_cell: assert property (p_sticky_cell) else $error("cell flag lost");

  property p_irq_level;
    irq && !(s_q.wr_pend && ((s_q.wr_addr == OFS_CLEAR) || (s_q.wr_addr == OFS_ENABLE)))
      |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq dropped without a write");

  property p_clear_err;
    s_q.wr_pend && (s_q.wr_addr == OFS_CLEAR) && hwdata[BIT_ADDR_ERR]
      |=> !s_q.flags[BIT_ADDR_ERR];
  endproperty
  a_clear_err: assert property (p_clear_err) else $error("address error not cleared");

  property p_abort;
    busy && abort_hit |=> !busy && s_q.flags[BIT_ABORT];
  endproperty
  a_abort: assert property (p_abort) else $error("abort not taken");

  property p_pattern;
    busy && !abort_hit && pattern_match |=> !busy && s_q.flags[BIT_BLOCK];
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern match missed");

  property p_cell;
    busy && !abort_hit && !pattern_match && xfer_ack && cell_wrap |=> s_q.flags[BIT_CELL];
  endproperty
  a_cell: assert property (p_cell) else $error("cell flag missed");

  property p_half;
    busy && !abort_hit && !pattern_match && xfer_ack && dst_half |=> s_q.flags[BIT_DHALF];
  endproperty
  a_half: assert property (p_half) else $error("half full flag missed");

  property p_addr_err;
    !busy && start_req && addr_bad |=> !busy && s_q.flags[BIT_ADDR_ERR];
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("address error missed");

  property p_src_range;
    busy |-> ({1'b0, src_ptr} < src_bytes);
  endproperty
  a_src_range: assert property (p_src_range) else $error("source pointer past length");

  sequence s_wr_dst_start;
    addr_phase && hwrite && (haddr[7:0] == OFS_DST_START) ##1 1'b1;
  endsequence

  property p_dst_start_rw;
    s_wr_dst_start |=> (s_q.dst_start == $past(hwdata));
  endproperty
  a_dst_start_rw: assert property (p_dst_start_rw) else $error("dest start not stored");

  sequence s_last_byte;
    busy && !abort_hit && !pattern_match && xfer_ack && (total_nxt == block_bytes);
  endsequence

  property p_block_done;
    s_last_byte |=> !busy && s_q.flags[BIT_BLOCK];
  endproperty
  a_block_done: assert property (p_block_done) else $error("block end missed");

  sequence s_start_ok;
    !busy && start_req && !addr_bad;
  endsequence

  property p_start_ok;
    s_start_ok |=> busy && (xfer.src == s_q.src_start) && (xfer.dst == s_q.dst_start)
      && (src_ptr == 16'h0000) && (dst_ptr == 16'h0000);
  endproperty
  a_start_ok: assert property (p_start_ok) else $error("start not taken");

  property p_idle_quiet;
    !busy |=> !$rose(s_q.flags[BIT_CELL]) && !$rose(s_q.flags[BIT_DHALF]);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("progress flag set while idle");

  property p_ptr_hold;
    !busy && !start_req |=> $stable(src_ptr) && $stable(dst_ptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved while idle");

endmodule

`default_nettype wire

// file: verification/dcf_mover.sv
/*
  Far-side byte mover model: acks one byte per cycle, or one per four when slow.
  Assumes xfer_req from the channel is a level held while bytes are owed.
*/
`default_nettype none

module dcf_mover (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic xfer_req,
  output logic xfer_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;

  // gap counter stalls the channel in slow mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_ack <= 1'b0;
      wait_q <= 2'b00;
    end else if (wait_q != 2'b00) begin
      xfer_ack <= 1'b0;
      wait_q <= wait_q - 2'b01;
    end else begin
      xfer_ack <= xfer_req;
      wait_q <= {2{slow & xfer_req}};
    end
  end
endmodule

`default_nettype wire

// file: verification/tb.sv
/*
  Self-checking bench for dcf_channel: bus tasks, note queue, mover model.
  Assumes dcf_pkg offsets and a zero-wait-state register port.
*/
`default_nettype none

module tb
  import dcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string name; logic [31:0] exp;} dcf_note_t;
  dcf_note_t notes[$];
  logic hclk, hresetn, hsel, hwrite, hrdy, hrsp, irq, busy, req, ack, slow, pm, obs_vld;
  logic [31:0] haddr, hwdata, hrdata, obs_val, lfsr_q, sa, da;
  logic [1:0] htrans;
  logic [7:0] sel;
  dcf_sysirq_t sys_irq;
  dcf_xfer_t xfer, xs;
  int failures, compares, acks;
  logic [47:0] lens [3] = '{48'h0003_0001_0003, 48'h0001_0004_0002, 48'h0000_0002_0100};
  logic [31:0] n_exp [3] = '{32'h0000_0003, 32'h0000_0004, 32'h0001_0000};
  logic [31:0] f_exp [3] = '{32'h0000_000c, 32'h0000_001c, 32'h0000_001c};

  dcf_channel #(.VALID_LO(32'h0000_1000), .VALID_HI(32'h0fff_ffff)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hresp(hrsp), .hrdata(hrdata), .irq(irq), .busy(busy), .xfer_req(req), .xfer(xfer),
    .xfer_ack(ack), .sys_irq(sys_irq), .pattern_match(pm));
  dcf_mover mover (.hclk(hclk), .hresetn(hresetn), .slow(slow), .xfer_req(req),
    .xfer_ack(ack));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // oldest note against the observed value
  always @(posedge hclk) begin
    if (obs_vld === 1'b1) begin
      compares++;
      if (obs_val !== notes[0].exp) begin
        failures++;
        $display("mismatch %s expected %h seen %h", notes[0].name, notes[0].exp, obs_val);
      end
      void'(notes.pop_front());
    end
    if (ack === 1'b1 && busy === 1'b1) acks++;
  end

  task automatic end_of_test;
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    notes.push_back('{n, e});
    obs_val <= g;
    obs_vld <= 1'b1;
    @(posedge hclk);
    obs_vld <= 1'b0;
    @(posedge hclk);
  endtask

  // which: 0 irq, 1 busy; sampled at the falling edge
  task automatic chk_bit(input string n, input logic e, input logic which);
    @(negedge hclk);
    chk(n, {31'h0, e}, {31'h0, which ? busy : irq});
  endtask

  task automatic step;
    for (int i = 0; i < 64; i++) begin
      @(posedge hclk);
      if (hrdy === 1'b1) return;
    end
    failures++;
    end_of_test;
  endtask

  task automatic wait_busy(input logic v);
    for (int i = 0; i < 70000; i++) begin
      @(negedge hclk);
      if (busy === v) begin
        xs = xfer;
        @(posedge hclk);
        return;
      end
    end
    failures++;
    end_of_test;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    step;
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    step;
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(n, e, hrdata);
  endtask

  task automatic run(input logic [31:0] s, d, input logic [15:0] sl, dl, cl,
                     input logic [31:0] ctl);
    bus(1'b1, OFS_SRC_START, s);
    bus(1'b1, OFS_DST_START, d);
    bus(1'b1, OFS_SRC_LEN, {16'h0000, sl});
    bus(1'b1, OFS_DST_LEN, {16'h0000, dl});
    bus(1'b1, OFS_CELL_LEN, {16'h0000, cl});
    acks = 0;
    bus(1'b1, OFS_CONTROL, ctl);
  endtask

  initial begin
    {hresetn, hsel, hwrite, slow, pm, obs_vld} = 6'h00;
    {haddr, hwdata, obs_val} = 96'h0;
    htrans = 2'b00;
    sys_irq = 9'h000;
    failures = 0;
    compares = 0;
    lfsr_q = 32'ha6b6;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("flags", OFS_FLAGS, 32'h0000_0000);
    rd("src_start", OFS_SRC_START, ADDR_RST);
    rd("dst_start", OFS_DST_START, ADDR_RST);
    rd("src_len", OFS_SRC_LEN, 32'h0000_0000);
    chk("hresp", 32'h0000_0000, {31'h0, hrsp});
    for (int k = 0; k < 4; k++) begin
      lfsr_q = lfsr(lfsr_q);
      da = ~lfsr_q;
      bus(1'b1, OFS_SRC_START, lfsr_q);
      bus(1'b1, OFS_DST_START, da);
      rd("src_start", OFS_SRC_START, lfsr_q);
      rd("dst_start", OFS_DST_START, da);
      bus(1'b1, OFS_SRC_LEN, da);
      rd("src_len", OFS_SRC_LEN, {16'h0000, da[15:0]});
    end
    rd("unmapped", 8'h3c, 32'h0000_0000);
    sa = {8'h01, lfsr_q[23:0]};
    bus(1'b1, OFS_ENABLE, 32'h0000_001f);
    slow <= 1'b1;
    run(sa, sa + 32'h0000_0100, 16'h0002, 16'h0002, 16'h0001, 32'h0000_0001);
    wait_busy(1'b1);
    chk("xfer_src", sa, xs.src);
    chk("xfer_dst", sa + 32'h0000_0100, xs.dst);
    wait_busy(1'b0);
    chk("acks", 32'h0000_0002, 32'(acks));
    rd("flags", OFS_FLAGS, 32'h0000_001c);
    chk_bit("irq", 1'b1, 1'b0);
    bus(1'b1, OFS_ENABLE, 32'h0000_0000);
    chk_bit("irq", 1'b0, 1'b0);
    rd("flags", OFS_FLAGS, 32'h0000_001c);
    bus(1'b1, OFS_CLEAR, 32'h0000_001f);
    rd("flags", OFS_FLAGS, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      slow <= (k < 2);
      run(sa, sa, lens[k][47:32], lens[k][31:16], lens[k][15:0], 32'h0000_0001);
      wait_busy(1'b1);
      wait_busy(1'b0);
      chk("acks", n_exp[k], 32'(acks));
      rd("flags", OFS_FLAGS, f_exp[k]);
      bus(1'b1, OFS_CLEAR, 32'h0000_001f);
    end
    slow <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      sel = k ? 8'hff : 8'h00;
      run(sa, sa, 16'h0000, 16'h0000, 16'h0100, {16'h0000, sel, 8'h03});
      wait_busy(1'b1);
      sys_irq <= {1'b1, ~sel};
      @(posedge hclk);
      sys_irq <= {1'b1, sel};
      chk_bit("busy", 1'b1, 1'b1);
      sys_irq <= 9'h000;
      chk_bit("busy", 1'b0, 1'b1);
      rd("flags", OFS_FLAGS, 32'h0000_0002);
      rd("dst_ptr", OFS_DST_PTR, 32'h0000_0001);
      rd("control", OFS_CONTROL, {16'h0000, sel, 8'h02});
      bus(1'b1, OFS_CLEAR, 32'h0000_001f);
    end
    run(sa, sa, 16'h0000, 16'h0000, 16'h0100, 32'h0000_0001);
    wait_busy(1'b1);
    pm <= 1'b1;
    sys_irq <= 9'h1ff;
    @(posedge hclk);
    pm <= 1'b0;
    sys_irq <= 9'h000;
    wait_busy(1'b0);
    rd("flags", OFS_FLAGS, 32'h0000_0008);
    bus(1'b1, OFS_CLEAR, 32'h0000_001f);
    bus(1'b1, OFS_ENABLE, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      run(k ? sa : 32'h0000_0ffc, k ? 32'h1000_0000 : sa, 16'h0001, 16'h0001, 16'h0001,
          32'h0000_0001);
      chk_bit("busy", 1'b0, 1'b1);
      rd("flags", OFS_FLAGS, 32'h0000_0001);
      chk_bit("irq", 1'b1, 1'b0);
      bus(1'b1, OFS_CLEAR, 32'h0000_001f);
      chk_bit("irq", 1'b0, 1'b0);
    end
    end_of_test;
  end
endmodule

`default_nettype wire
